// ---- dv/compare_skip_branch_unit_tb.sv ----
// self-checking bench for the compare, skip and branch unit
`timescale 1ns/100ps
module compare_skip_branch_unit_tb;
   import csb_pkg::*;
   localparam logic [7:0] MSK [18] = '{8'h01, 8'h01, 8'h02, 8'h02, 8'h01, 8'h01, 8'h01, 8'h01, 8'h04, 8'h04,
      8'h04, 8'h04, 8'h20, 8'h20, 8'h40, 8'h40, 8'h08, 8'h08};
   localparam logic [17:0] POL = 18'h15995;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   wire logic hready;
   wire logic [31:0] hrdata;
   wire logic hresp;
   wire logic [15:0] pc_out;
   wire logic [7:0] status_out;
   wire logic busy;
   int fail_count = 0;
   int checked = 0;
   logic [31:0] rd;

   always #20 clk = ~clk;

   compare_skip_branch_unit dut_u (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
      .hresp(hresp), .pc_out(pc_out), .status_out(status_out), .busy(busy));

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic test_done;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done

   // one single word transfer, entered just after a rising edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h000000, a};
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask : bus

   task automatic exec(input logic [7:0] opb, input logic [31:0] opnd, input logic [7:0] k, input logic [7:0] st,
         input logic [15:0] pc, input int cyc, input logic [15:0] epc, input logic [7:0] est);
      int n;
      bus(1'b1, ADDR_OPERAND, opnd);
      bus(1'b1, ADDR_OFFSET, {24'h000000, k});
      bus(1'b1, ADDR_STATUS, {24'h000000, st});
      bus(1'b1, ADDR_PC, {16'h0000, pc});
      bus(1'b1, ADDR_OP, {24'h000000, opb});
      n = 0;
      @(posedge clk);
      while (busy === 1'b1 && n < 8) begin
         n++;
         @(posedge clk);
      end
      chk("cycles", n, cyc);
      bus(1'b0, ADDR_PC, 32'h0);
      chk("pc", rd, {16'h0000, epc});
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk("status", rd, {24'h000000, est});
   endtask : exec

   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      test_done();
   end

   initial begin
      logic [7:0] m;
      logic [7:0] t;
      logic [6:0] kk;
      logic [15:0] p0;
      logic [7:0] ob;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      bus(1'b0, ADDR_PC, 32'h0);
      chk("pc reset", rd, 32'h0);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk("status reset", rd, 32'h0);
      chk("ready okay", {30'h0, hready, hresp}, 32'h2);
      bus(1'b1, 8'h18, 32'hFFFFFFFF);
      bus(1'b0, 8'h18, 32'h0);
      chk("unmapped", rd, 32'h0);
      $display("test reset and map done");
      exec(8'h00, 32'h00002010, 8'h00, 8'hD0, 16'h0010, 1, 16'h0011, 8'hD5);
      exec(8'h02, 32'h00000180, 8'h00, 8'h00, 16'h0010, 1, 16'h0011, 8'h28);
      exec(8'h01, 32'h00000505, 8'h00, 8'h03, 16'h0010, 1, 16'h0011, 8'h25);
      exec(8'h01, 32'h00000405, 8'h00, 8'h01, 16'h0010, 1, 16'h0011, 8'h00);
      $display("test compares done");
      exec(8'h03, 32'h01005A5A, 8'h00, 8'hFF, 16'hFFFE, 3, 16'h0001, 8'hFF);
      exec(8'h03, 32'h00005A5B, 8'h00, 8'hFF, 16'h0100, 1, 16'h0101, 8'hFF);
      exec(8'h84, 32'h0000EF00, 8'h00, 8'hFF, 16'h0100, 2, 16'h0102, 8'hFF);
      exec(8'h85, 32'h0000EF00, 8'h00, 8'hFF, 16'h0100, 1, 16'h0101, 8'hFF);
      exec(8'hE7, 32'h01800000, 8'h00, 8'hFF, 16'h0100, 3, 16'h0103, 8'hFF);
      exec(8'hE6, 32'h01800000, 8'h00, 8'hFF, 16'h0100, 1, 16'h0101, 8'hFF);
      exec(8'h1A, 32'h0, 8'h00, 8'h5A, 16'h0200, 0, 16'h0200, 8'h5A);
      bus(1'b0, ADDR_RESULT, 32'h0);
      chk("invalid flag", rd & 32'h10, 32'h10);
      $display("test skips done");
      for (int i = 0; i < 18; i++) begin
         for (int s = 0; s < 8; s++) begin
            if (i < 2 || s == 0) begin
               m = (i < 2) ? 8'h01 << s : MSK[i];
               t = POL[i] ? m : 8'h00;
               kk = i[0] ? 7'h7E : 7'h05;
               p0 = i[0] ? 16'h0001 : 16'hFFFE;
               ob = {s[2:0], 5'h08 + i[4:0]};
               exec(ob, 32'h0, {1'b0, kk}, t, p0, 2, p0 + {{9{kk[6]}}, kk} + 16'h0001, t);
               exec(ob, 32'h0, {1'b0, kk}, t ^ m, p0, 1, p0 + 16'h0001, t ^ m);
            end
         end
      end
      $display("test branches done");
      bus(1'b1, ADDR_OPERAND, 32'h01003C3C);
      bus(1'b1, ADDR_PC, 32'h00000020);
      bus(1'b1, ADDR_OP, 32'h00000003);
      bus(1'b1, ADDR_PC, 32'h00001234);
      repeat (4) @(posedge clk);
      bus(1'b0, ADDR_PC, 32'h0);
      chk("pc after refusal", rd, 32'h00000023);
      bus(1'b0, ADDR_RESULT, 32'h0);
      chk("result", rd & 32'h2F, 32'h27);
      $display("test refusal done");
      test_done();
   end
endmodule : compare_skip_branch_unit_tb

// ---- dv/csb_chk.sv ----
// port assertions for the compare, skip and branch unit
`timescale 1ns/100ps
module csb_chk
   import csb_pkg::*;
#(
   parameter int PC_WIDTH = 16,
   parameter int OFFSET_WIDTH = 7
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [PC_WIDTH-1:0] pc_out,
   input wire logic [7:0] status_out,
   input wire logic busy
);
   logic wr_q;
   logic [31:0] addr_q;
   logic two_q;
   logic [OFFSET_WIDTH-1:0] k_q;
   logic [PC_WIDTH-1:0] pc_l;
   wire logic wr_op = wr_q && addr_q == {24'h000000, ADDR_OP};
   wire logic [4:0] opc = hwdata[4:0];
   wire logic launch = wr_op && !busy && opc <= 5'h19;
   wire logic is_cmp = opc <= 5'h02;
   wire logic is_skip = opc >= 5'h03 && opc <= 5'h07;
   wire logic is_br = opc >= 5'h08;
   wire logic [PC_WIDTH-1:0] pc1 = pc_l + 2'h1;
   wire logic [PC_WIDTH-1:0] pc2 = pc_l + 2'h2;
   wire logic [PC_WIDTH-1:0] pc3 = pc_l + 2'h3;
   wire logic [PC_WIDTH-1:0] tgt = pc_l + {{(PC_WIDTH-OFFSET_WIDTH){k_q[OFFSET_WIDTH-1]}}, k_q} + 1'b1;

   // shadow of operand, offset and launch pc
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_q <= 1'b0;
         addr_q <= 32'h0;
         two_q <= 1'b0;
         k_q <= '0;
         pc_l <= '0;
      end else begin
         wr_q <= hsel && htrans[1] && hready && hwrite;
         addr_q <= haddr;
         if (wr_q && addr_q == {24'h000000, ADDR_OPERAND}) begin
            two_q <= hwdata[TWO_WORD_BIT];
         end
         if (wr_q && addr_q == {24'h000000, ADDR_OFFSET}) begin
            k_q <= hwdata[OFFSET_WIDTH-1:0];
         end
         if (launch) begin
            pc_l <= pc_out;
         end
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   property p_cmp_len;
      launch && is_cmp |=> busy ##1 !busy;
   endproperty
   a_cmp_len: assert property (p_cmp_len) else $error("compare not one cycle");
   property p_cmp_pc;
      launch && is_cmp |=> ##1 pc_out == pc1;
   endproperty
   a_cmp_pc: assert property (p_cmp_pc) else $error("compare pc wrong");
   property p_br;
      launch && is_br |=> busy ##1 ((!busy && pc_out == pc1) or (busy ##1 (!busy && pc_out == tgt)));
   endproperty
   a_br: assert property (p_br) else $error("branch pc or length wrong");
   property p_skip1;
      launch && is_skip && !two_q |=> busy ##1 ((!busy && pc_out == pc1) or (busy ##1 (!busy && pc_out == pc2)));
   endproperty
   a_skip1: assert property (p_skip1) else $error("one word skip wrong");
   property p_skip2;
      launch && is_skip && two_q |=> busy ##1 ((!busy && pc_out == pc1) or (busy[*2] ##1 (!busy && pc_out == pc3)));
   endproperty
   a_skip2: assert property (p_skip2) else $error("two word skip wrong");
   property p_flags;
      launch && !is_cmp |=> $stable(status_out)[*4];
   endproperty
   a_flags: assert property (p_flags) else $error("flags changed by skip or branch");
   property p_busy_max;
      busy[*3] |=> !busy;
   endproperty
   a_busy_max: assert property (p_busy_max) else $error("busy over three cycles");
   property p_busy_cause;
      !busy && !launch |=> !busy;
   endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("busy without launch");

   c_cmp: cover property (launch && is_cmp);
   c_taken: cover property (launch && is_br ##2 busy);
   c_skip2: cover property (launch && is_skip && two_q ##3 busy);
endmodule : csb_chk

bind compare_skip_branch_unit csb_chk #(.PC_WIDTH(PC_WIDTH), .OFFSET_WIDTH(OFFSET_WIDTH)) chk_u (.clk, .resetn,
   .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pc_out, .status_out, .busy);

// ---- logic/compare_skip_branch_unit.sv ----
// compare, conditional skip and conditional branch unit with AHB-Lite register port
// Functional notes
// - equal registers skip next; 1/2/3 cycles
// - compares subtract, set Z N V C H
// - register bit skip, clear or set variant
// - I/O bit skip, clear or set variant
// - status bit branch: pc plus k plus one
// - equal/not-equal branch on zero flag
// - carry set/lower, carry clear/same-higher
// - minus/plus on negative; taken two cycles
// - signed greater-equal when N xor V zero
// - half-carry set and clear branches
// - T flag set and clear branches
// - overflow branches; skips keep all flags
//
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/100ps
module compare_skip_branch_unit #(
   parameter int PC_WIDTH = 16,
   parameter int OFFSET_WIDTH = 7
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic [PC_WIDTH-1:0] pc_out,
   output logic [7:0] status_out,
   output logic busy
);
   import csb_pkg::*;

   // reset release through two flops
   logic rst_meta_n;
   logic rst_n;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_n <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n <= rst_meta_n;
      end
   end

   // register state
   logic [7:0] rd_val;
   logic [7:0] rr_val;
   logic [7:0] io_val;
   logic two_word;
   logic [OFFSET_WIDTH-1:0] offset;
   logic [7:0] status;
   logic [PC_WIDTH-1:0] pc;
   logic [1:0] last_cycles;
   logic last_skip;
   logic last_taken;
   logic last_invalid;
   logic refused;
   state_t state;
   logic [1:0] count;
   logic [PC_WIDTH-1:0] pend_pc;
   logic [7:0] pend_status;

   // bus address phase capture
   logic wr_pend;
   logic [ADDR_DECODE_WIDTH-1:0] wr_addr;

   wire logic addr_phase = hsel & htrans[1] & hready;
   wire logic mapped = (haddr[31:ADDR_DECODE_WIDTH] == '0) && (haddr[1:0] == 2'h0);
   wire logic rd_take = addr_phase & ~hwrite;
   wire logic wr_take = addr_phase & hwrite & mapped;

   wire logic wr_op = wr_pend && (wr_addr == ADDR_OP);
   wire logic wr_operand = wr_pend && (wr_addr == ADDR_OPERAND);
   wire logic wr_offset = wr_pend && (wr_addr == ADDR_OFFSET);
   wire logic wr_status = wr_pend && (wr_addr == ADDR_STATUS);
   wire logic wr_pc = wr_pend && (wr_addr == ADDR_PC);
   wire logic wr_result = wr_pend && (wr_addr == ADDR_RESULT);
   wire logic idle = (state == ST_IDLE);

   // evaluator fed straight from the op write
   cond_if cif ();
   assign cif.op = hwdata[OP_MSB:OP_LSB];
   assign cif.sel = hwdata[SEL_MSB:SEL_LSB];
   assign cif.status = status;
   assign cif.rd = rd_val;
   assign cif.rr = rr_val;
   assign cif.io = io_val;

   cond_eval u_eval (
      .c(cif.eval)
   );

   wire logic launch = wr_op & idle & cif.valid;
   wire logic bad_op = wr_op & idle & ~cif.valid;
   wire logic busy_write = (wr_op | wr_status | wr_pc) & ~idle;

   // next program counter
   wire logic [PC_WIDTH-1:0] k_ext = PC_WIDTH'($signed(offset));
   wire logic [PC_WIDTH-1:0] pc_step = pc + PC_WIDTH'(1);
   wire logic [PC_WIDTH-1:0] pc_branch = pc + k_ext + PC_WIDTH'(1);
   wire logic [PC_WIDTH-1:0] pc_skip = two_word ? pc + PC_WIDTH'(3) : pc + PC_WIDTH'(2);
   wire logic skip_now = cif.is_skip & cif.hit;
   wire logic take_now = cif.is_branch & cif.hit;
   wire logic [PC_WIDTH-1:0] next_pc = skip_now ? pc_skip : (take_now ? pc_branch : pc_step);

   // cycles spent by this outcome
   wire logic [1:0] skip_cycles = two_word ? CYC_SKIP_TWO_WORD : CYC_SKIP_ONE_WORD;
   wire logic [1:0] next_cycles = cif.is_compare ? CYC_COMPARE :
                                  skip_now ? skip_cycles :
                                  take_now ? CYC_BRANCH_TAKEN : CYC_NOT_TAKEN;

   wire logic finish = (state == ST_RUN) && (count == 2'h0);
   wire logic [1:0] next_count = (state == ST_RUN) ? count - 2'h1 : count;
   wire logic clear_refused = wr_result & hwdata[RES_REFUSED_BIT];
   wire logic next_refused = busy_write | (refused & ~clear_refused);

   // read mux
   wire logic [31:0] result_word = {25'h0, ~idle, refused, last_invalid, last_taken, last_skip, last_cycles};
   wire logic [ADDR_DECODE_WIDTH-1:0] rd_addr = haddr[ADDR_DECODE_WIDTH-1:0];
   wire logic [31:0] read_word =
      !mapped ? WORD_ZERO :
      (rd_addr == ADDR_OPERAND) ? {7'h00, two_word, io_val, rr_val, rd_val} :
      (rd_addr == ADDR_OFFSET) ? 32'(offset) :
      (rd_addr == ADDR_STATUS) ? {24'h000000, status} :
      (rd_addr == ADDR_PC) ? 32'(pc) :
      (rd_addr == ADDR_RESULT) ? result_word : WORD_ZERO;

   // bus slave: zero wait states, always OKAY
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_pend <= 1'b0;
         wr_addr <= '0;
         hrdata <= WORD_ZERO;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_pend <= wr_take;
         wr_addr <= haddr[ADDR_DECODE_WIDTH-1:0];
         if (rd_take) begin
            hrdata <= read_word;
         end
      end
   end

   // operand registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_val <= 8'h00;
         rr_val <= 8'h00;
         io_val <= 8'h00;
         two_word <= 1'b0;
         offset <= '0;
      end else begin
         if (wr_operand) begin
            rd_val <= hwdata[RD_LSB+7:RD_LSB];
            rr_val <= hwdata[RR_LSB+7:RR_LSB];
            io_val <= hwdata[IO_LSB+7:IO_LSB];
            two_word <= hwdata[TWO_WORD_BIT];
         end
         if (wr_offset) begin
            offset <= hwdata[OFFSET_WIDTH-1:0];
         end
      end
   end

   // execution sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         count <= 2'h0;
         pend_pc <= PC_RESET[PC_WIDTH-1:0];
         pend_status <= STATUS_RESET;
      end else begin
         case (state)
            ST_IDLE: begin
               if (launch) begin
                  state <= ST_RUN;
                  count <= next_cycles - 2'h1;
                  pend_pc <= next_pc;
                  pend_status <= cif.next_status;
               end
            end
            ST_RUN: begin
               count <= next_count;
               if (finish) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // architectural state and outcome report
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status <= STATUS_RESET;
         pc <= PC_RESET[PC_WIDTH-1:0];
         last_cycles <= 2'h0;
         last_skip <= 1'b0;
         last_taken <= 1'b0;
         last_invalid <= 1'b0;
         refused <= 1'b0;
      end else begin
         refused <= next_refused;
         if (finish) begin
            status <= pend_status;
            pc <= pend_pc;
         end else if (idle) begin
            if (wr_status) begin
               status <= hwdata[7:0];
            end
            if (wr_pc) begin
               pc <= hwdata[PC_WIDTH-1:0];
            end
         end
         if (launch) begin
            last_cycles <= next_cycles;
            last_skip <= skip_now;
            last_taken <= take_now;
            last_invalid <= 1'b0;
         end else if (bad_op) begin
            last_invalid <= 1'b1;
         end
      end
   end

   // mirrored outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_out <= PC_RESET[PC_WIDTH-1:0];
         status_out <= STATUS_RESET;
         busy <= 1'b0;
      end else begin
         pc_out <= finish ? pend_pc : (idle && wr_pc) ? hwdata[PC_WIDTH-1:0] : pc;
         status_out <= finish ? pend_status : (idle && wr_status) ? hwdata[7:0] : status;
         busy <= launch | ((state == ST_RUN) & ~finish);
      end
   end
endmodule : compare_skip_branch_unit

// ---- logic/cond_eval.sv ----
// condition and compare flag evaluator
`timescale 1ns/100ps
module cond_eval (
   cond_if.eval c
);
   import csb_pkg::*;

   function automatic logic bit_of(input logic [7:0] v, input logic [2:0] s);
      return v[s];
   endfunction : bit_of

   function automatic logic cond_of(input logic [4:0] op, input logic [2:0] s, input logic [7:0] st,
                                    input logic [7:0] rd, input logic [7:0] rr, input logic [7:0] io);
      logic r;
      r = 1'b0;
      case (op)
         OP_COMPARE_SKIP_EQUAL: r = (rd == rr);
         OP_SKIP_REG_BIT_CLEAR: r = ~bit_of(rr, s);
         OP_SKIP_REG_BIT_SET: r = bit_of(rr, s);
         OP_SKIP_IO_BIT_CLEAR: r = ~bit_of(io, s);
         OP_SKIP_IO_BIT_SET: r = bit_of(io, s);
         OP_BRANCH_STATUS_BIT_SET: r = bit_of(st, s);
         OP_BRANCH_STATUS_BIT_CLEAR: r = ~bit_of(st, s);
         OP_BRANCH_EQUAL: r = st[SB_Z];
         OP_BRANCH_NOT_EQUAL: r = ~st[SB_Z];
         OP_BRANCH_CARRY_SET: r = st[SB_C];
         OP_BRANCH_LOWER: r = st[SB_C];
         OP_BRANCH_CARRY_CLEAR: r = ~st[SB_C];
         OP_BRANCH_SAME_HIGHER: r = ~st[SB_C];
         OP_BRANCH_MINUS: r = st[SB_N];
         OP_BRANCH_PLUS: r = ~st[SB_N];
         OP_BRANCH_SIGNED_GE: r = ~(st[SB_N] ^ st[SB_V]);
         OP_BRANCH_SIGNED_LT: r = st[SB_N] ^ st[SB_V];
         OP_BRANCH_HALFCARRY_SET: r = st[SB_H];
         OP_BRANCH_HALFCARRY_CLEAR: r = ~st[SB_H];
         OP_BRANCH_TFLAG_SET: r = st[SB_T];
         OP_BRANCH_TFLAG_CLEAR: r = ~st[SB_T];
         OP_BRANCH_OVERFLOW_SET: r = st[SB_V];
         OP_BRANCH_OVERFLOW_CLEAR: r = ~st[SB_V];
         default: r = 1'b0;
      endcase
      return r;
   endfunction : cond_of

   // subtraction without storing the result
   wire logic with_carry = (c.op == OP_COMPARE_REGS_CARRY);
   wire logic carry_in = with_carry & c.status[SB_C];
   wire logic [7:0] diff = c.rd - c.rr - {7'h00, carry_in};
   wire logic flag_h = (~c.rd[3] & c.rr[3]) | (c.rr[3] & diff[3]) | (diff[3] & ~c.rd[3]);
   wire logic flag_v = (c.rd[7] & ~c.rr[7] & ~diff[7]) | (~c.rd[7] & c.rr[7] & diff[7]);
   wire logic flag_c = (~c.rd[7] & c.rr[7]) | (c.rr[7] & diff[7]) | (diff[7] & ~c.rd[7]);
   wire logic diff_zero = (diff == 8'h00);
   wire logic flag_z = with_carry ? (diff_zero & c.status[SB_Z]) : diff_zero;
   wire logic [7:0] cmp_status = {c.status[SB_I], c.status[SB_T], flag_h, c.status[SB_S],
                                  flag_v, diff[7], flag_z, flag_c};

   assign c.is_compare = (c.op <= OP_COMPARE_IMMEDIATE);
   assign c.is_skip = (c.op >= OP_COMPARE_SKIP_EQUAL) && (c.op <= OP_SKIP_IO_BIT_SET);
   assign c.is_branch = (c.op >= OP_BRANCH_STATUS_BIT_SET) && (c.op <= OP_BRANCH_OVERFLOW_CLEAR);
   assign c.valid = c.is_compare | c.is_skip | c.is_branch;
   assign c.hit = cond_of(c.op, c.sel, c.status, c.rd, c.rr, c.io);
   // skips and branches keep every flag
   assign c.next_status = c.is_compare ? cmp_status : c.status;
endmodule : cond_eval

// ---- pkg/cond_if.sv ----
// signals between the unit core and its condition evaluator
`timescale 1ns/100ps
interface cond_if;
   logic [4:0] op;
   logic [2:0] sel;
   logic [7:0] status;
   logic [7:0] rd;
   logic [7:0] rr;
   logic [7:0] io;
   logic valid;
   logic is_compare;
   logic is_skip;
   logic is_branch;
   logic hit;
   logic [7:0] next_status;
   modport core (output op, sel, status, rd, rr, io,
                 input valid, is_compare, is_skip, is_branch, hit, next_status);
   modport eval (input op, sel, status, rd, rr, io,
                 output valid, is_compare, is_skip, is_branch, hit, next_status);
endinterface : cond_if

// ---- pkg/csb_pkg.sv ----
// constants, types and register map of the compare, skip and branch unit
package csb_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_OP = 8'h00;
   localparam logic [7:0] ADDR_OPERAND = 8'h04;
   localparam logic [7:0] ADDR_OFFSET = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_PC = 8'h10;
   localparam logic [7:0] ADDR_RESULT = 8'h14;
   localparam int ADDR_DECODE_WIDTH = 8;

   // op register fields
   localparam int OP_LSB = 0;
   localparam int OP_MSB = 4;
   localparam int SEL_LSB = 5;
   localparam int SEL_MSB = 7;

   // operand register fields
   localparam int RD_LSB = 0;
   localparam int RR_LSB = 8;
   localparam int IO_LSB = 16;
   localparam int TWO_WORD_BIT = 24;

   // result register fields
   localparam int RES_CYC_LSB = 0;
   localparam int RES_SKIP_BIT = 2;
   localparam int RES_TAKEN_BIT = 3;
   localparam int RES_INVALID_BIT = 4;
   localparam int RES_REFUSED_BIT = 5;
   localparam int RES_BUSY_BIT = 6;

   // status register bit positions
   localparam int SB_C = 0;
   localparam int SB_Z = 1;
   localparam int SB_N = 2;
   localparam int SB_V = 3;
   localparam int SB_S = 4;
   localparam int SB_H = 5;
   localparam int SB_T = 6;
   localparam int SB_I = 7;

   // values after reset
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [31:0] PC_RESET = 32'h0000_0000;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // cycle counts per outcome
   localparam logic [1:0] CYC_COMPARE = 2'h1;
   localparam logic [1:0] CYC_NOT_TAKEN = 2'h1;
   localparam logic [1:0] CYC_BRANCH_TAKEN = 2'h2;
   localparam logic [1:0] CYC_SKIP_ONE_WORD = 2'h2;
   localparam logic [1:0] CYC_SKIP_TWO_WORD = 2'h3;

   typedef enum logic [4:0] {
      OP_COMPARE_REGS = 5'h00,
      OP_COMPARE_REGS_CARRY = 5'h01,
      OP_COMPARE_IMMEDIATE = 5'h02,
      OP_COMPARE_SKIP_EQUAL = 5'h03,
      OP_SKIP_REG_BIT_CLEAR = 5'h04,
      OP_SKIP_REG_BIT_SET = 5'h05,
      OP_SKIP_IO_BIT_CLEAR = 5'h06,
      OP_SKIP_IO_BIT_SET = 5'h07,
      OP_BRANCH_STATUS_BIT_SET = 5'h08,
      OP_BRANCH_STATUS_BIT_CLEAR = 5'h09,
      OP_BRANCH_EQUAL = 5'h0A,
      OP_BRANCH_NOT_EQUAL = 5'h0B,
      OP_BRANCH_CARRY_SET = 5'h0C,
      OP_BRANCH_CARRY_CLEAR = 5'h0D,
      OP_BRANCH_SAME_HIGHER = 5'h0E,
      OP_BRANCH_LOWER = 5'h0F,
      OP_BRANCH_MINUS = 5'h10,
      OP_BRANCH_PLUS = 5'h11,
      OP_BRANCH_SIGNED_GE = 5'h12,
      OP_BRANCH_SIGNED_LT = 5'h13,
      OP_BRANCH_HALFCARRY_SET = 5'h14,
      OP_BRANCH_HALFCARRY_CLEAR = 5'h15,
      OP_BRANCH_TFLAG_SET = 5'h16,
      OP_BRANCH_TFLAG_CLEAR = 5'h17,
      OP_BRANCH_OVERFLOW_SET = 5'h18,
      OP_BRANCH_OVERFLOW_CLEAR = 5'h19
   } op_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN = 1'b1
   } state_t;
endpackage : csb_pkg
